// ### ddo_pkg.sv
// direct data command handler: shared constants, image layout, states
// assumes one 100 MHz clock shared by scanner end and device end
package ddo_pkg;
	// image byte offsets within the cyclic output image
	localparam int FIXED_IN_BYTE   = 4;
	localparam int OP_TYPE_BYTE    = 6;
	localparam int POSITION_BYTE   = 8;
	localparam int SPEED_BYTE      = 12;
	localparam int START_RATE_BYTE = 16;
	localparam int STOP_DECEL_BYTE = 20;
	localparam int CURRENT_BYTE    = 24;
	localparam int FORWARD_BYTE    = 26;
	localparam int PARAM_ID_BYTE   = 34;
	localparam int PARAM_VAL_BYTE  = 36;
	// position of the launch condition bit inside the fixed input word
	localparam int LAUNCH_COND_BIT = 9;

	// trigger field selection parameter
	localparam logic [15:0] FIELD_SEL_ID    = 16'h6114;
	localparam logic [31:0] FIELD_SEL_RESET = 32'h0000_0001;
	localparam logic [31:0] SEL_DISABLE    = 32'h0000_0000;
	localparam logic [31:0] SEL_ALL        = 32'h0000_0001;
	localparam logic [31:0] SEL_OP_TYPE    = 32'hffff_fffa;
	localparam logic [31:0] SEL_POSITION   = 32'hffff_fffb;
	localparam logic [31:0] SEL_SPEED      = 32'hffff_fffc;
	localparam logic [31:0] SEL_START_RATE = 32'hffff_fffd;
	localparam logic [31:0] SEL_STOP_DECEL = 32'hffff_fffe;
	localparam logic [31:0] SEL_CURRENT    = 32'hffff_ffff;

	// forwarding destinations and continuous operation types
	localparam logic [15:0] FWD_EXEC     = 16'h0000;
	localparam logic [15:0] FWD_BUFFER   = 16'h0001;
	localparam logic [15:0] OP_CONT_POS  = 16'h0007;
	localparam logic [15:0] OP_CONT_SPD  = 16'h0010;
	localparam logic [15:0] OP_CONT_TRQ  = 16'h0011;

	// fields, in the order used by the change compare
	localparam int NUM_FIELDS = 6;

	typedef struct packed {
		logic [15:0] op_type;
		logic [31:0] position;
		logic [31:0] speed;
		logic [31:0] start_rate;
		logic [31:0] stop_decel;
		logic [15:0] current;
	} direct_data_s;

	// host controller register map (word index on the host command port)
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_OP_TYPE  = 4'h1;
	localparam logic [3:0] REG_POSITION = 4'h2;
	localparam logic [3:0] REG_SPEED    = 4'h3;
	localparam logic [3:0] REG_RATE     = 4'h4;
	localparam logic [3:0] REG_DECEL    = 4'h5;
	localparam logic [3:0] REG_CURRENT  = 4'h6;
	localparam logic [3:0] REG_FORWARD  = 4'h7;
	localparam logic [3:0] REG_PARAM_ID = 4'h8;
	localparam logic [3:0] REG_PARAM_V  = 4'h9;
	localparam logic [3:0] REG_STATUS   = 4'ha;
	localparam logic [3:0] REG_EVENTS   = 4'hb;
	localparam logic [3:0] REG_MASK     = 4'hc;
	// ctrl bits
	localparam int CTRL_LAUNCH = 0;
	localparam int CTRL_WRREQ  = 1;
	localparam int CTRL_LEVEL  = 2;
	// event bits
	localparam int EV_ACK  = 0;
	localparam int EV_DONE = 1;
	localparam int EV_FULL = 2;
	localparam int NUM_EV  = 3;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_BUSY = 3'b010,
		WR_DONE = 3'b100
	} wr_state_e;
endpackage : ddo_pkg

// ### ddo_if.sv
// link between fieldbus scanner end and driver end
// assumes both ends share clk_in; scanner owns the output image
`timescale 1ns/1ns
interface ddo_if;
	logic [15:0]           fixed_in;
	ddo_pkg::direct_data_s data;
	logic [15:0]           forward;
	logic [15:0]           param_id;
	logic [31:0]           param_val;
	logic                  write_request;
	logic                  write_done;
	logic                  direct_command_ready;
	logic                  launch_acknowledge;
	logic                  queue_slot_full;

	modport scanner (
		output fixed_in, data, forward, param_id, param_val, write_request,
		input  write_done, direct_command_ready, launch_acknowledge,
		input  queue_slot_full
	);
	modport driver (
		input  fixed_in, data, forward, param_id, param_val, write_request,
		output write_done, direct_command_ready, launch_acknowledge,
		output queue_slot_full
	);
endinterface : ddo_if

// ### direct_data_command_handler.sv
// driver end: launch detection, execution and buffer slots, param write
// assumes the motion generator reports completion via op_complete_in;
// link inputs come from another device, so they are synchronised here
`timescale 1ns/1ns
// Operation
// - dest 0 launch replaces running data
// - exec load under dest 0 clears buffer
// - dest 1 buffers; starts after completion
// - buffer holds exactly one entry
// - queue full while buffer holds entry
// - stopped or continuous ignores buffer selection
// - bit 9 picks edge or level start
// - scanner checks ready before launch (ddo_scanner passes the launch bit from software without checking ready)
// - edge start acknowledged; scanner waits ack (ddo_scanner does not wait for the ack; software drops the launch bit)
// - param write request, done when applied
// - done drops after request drops
// - image field byte layout
// - selection id 24852, minus five position
// - level mode position change launches
// - other field change ignored for position
// - selection applies only in level mode
// - all-field or disable selections
module direct_data_command_handler (
	// clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               clk_en_in,
	// link
	ddo_if.driver                   link,
	// motion generator side
	input  wire logic               motor_running_in,
	input  wire logic               op_complete_in,
	output logic                    exec_start_out,
	output ddo_pkg::direct_data_s   exec_data_out,
	output logic [31:0]             field_sel_out
);
	// two-stage sync of every link input
	logic [15:0]           fixed_s1, fixed_s2;
	ddo_pkg::direct_data_s data_s1, data_s2;
	logic [15:0]           fwd_s1, fwd_s2;
	logic [15:0]           pid_s1, pid_s2;
	logic [31:0]           pval_s1, pval_s2;
	logic                  wreq_s1, wreq_s2;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fixed_s1 <= 16'h0;
			fixed_s2 <= 16'h0;
			data_s1  <= '0;
			data_s2  <= '0;
			fwd_s1   <= 16'h0;
			fwd_s2   <= 16'h0;
			pid_s1   <= 16'h0;
			pid_s2   <= 16'h0;
			pval_s1  <= 32'h0;
			pval_s2  <= 32'h0;
			wreq_s1  <= 1'b0;
			wreq_s2  <= 1'b0;
		end else if (clk_en_in) begin
			fixed_s1 <= link.fixed_in;
			fixed_s2 <= fixed_s1;
			data_s1  <= link.data;
			data_s2  <= data_s1;
			fwd_s1   <= link.forward;
			fwd_s2   <= fwd_s1;
			pid_s1   <= link.param_id;
			pid_s2   <= pid_s1;
			pval_s1  <= link.param_val;
			pval_s2  <= pval_s1;
			wreq_s1  <= link.write_request;
			wreq_s2  <= wreq_s1;
		end
	end

	logic launch_in, level_mode, launch_prev;
	assign launch_in  = fixed_s2[0];
	assign level_mode = fixed_s2[ddo_pkg::LAUNCH_COND_BIT];

	// parameter write handshake
	ddo_pkg::wr_state_e wr_state;
	logic [31:0]        field_sel;

	// only the field selection id is stored; other ids are acknowledged
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			field_sel <= ddo_pkg::FIELD_SEL_RESET;
		else if (clk_en_in && wr_state == ddo_pkg::WR_BUSY &&
			pid_s2 == ddo_pkg::FIELD_SEL_ID)
			field_sel <= pval_s2;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_state <= ddo_pkg::WR_IDLE;
		end else if (clk_en_in) begin
			unique case (wr_state)
				ddo_pkg::WR_IDLE: begin
					if (wreq_s2)
						wr_state <= ddo_pkg::WR_BUSY;
				end
				ddo_pkg::WR_BUSY: begin
					wr_state <= ddo_pkg::WR_DONE;
				end
				ddo_pkg::WR_DONE: begin
					if (!wreq_s2)
						wr_state <= ddo_pkg::WR_IDLE;
				end
				default: wr_state <= ddo_pkg::WR_IDLE;
			endcase
		end
	end

	// per-field change compare against the last accepted launch
	ddo_pkg::direct_data_s latched;
	logic [ddo_pkg::NUM_FIELDS-1:0] changed;
	assign changed[5] = data_s2.op_type    != latched.op_type;
	assign changed[4] = data_s2.position   != latched.position;
	assign changed[3] = data_s2.speed      != latched.speed;
	assign changed[2] = data_s2.start_rate != latched.start_rate;
	assign changed[1] = data_s2.stop_decel != latched.stop_decel;
	assign changed[0] = data_s2.current    != latched.current;

	logic field_fire;
	always_comb begin
		unique case (field_sel)
			ddo_pkg::SEL_ALL:        field_fire = |changed;
			ddo_pkg::SEL_OP_TYPE:    field_fire = changed[5];
			ddo_pkg::SEL_POSITION:   field_fire = changed[4];
			ddo_pkg::SEL_SPEED:      field_fire = changed[3];
			ddo_pkg::SEL_START_RATE: field_fire = changed[2];
			ddo_pkg::SEL_STOP_DECEL: field_fire = changed[1];
			ddo_pkg::SEL_CURRENT:    field_fire = changed[0];
			default:                 field_fire = 1'b0;
		endcase
	end

	// level mode: rising edge launches, then field changes re-launch
	logic rise, launch_ev, lvl_disabled;
	assign rise         = launch_in && !launch_prev;
	assign lvl_disabled = level_mode && field_sel == ddo_pkg::SEL_DISABLE;
	// selection only consulted when level_mode is set
	assign launch_ev = !lvl_disabled &&
		(rise || (level_mode && launch_in && field_fire));

	logic continuous, to_buffer;
	assign continuous = exec_data_out.op_type == ddo_pkg::OP_CONT_POS ||
		exec_data_out.op_type == ddo_pkg::OP_CONT_SPD ||
		exec_data_out.op_type == ddo_pkg::OP_CONT_TRQ;
	// buffering only while a finite move runs
	assign to_buffer = fwd_s2 == ddo_pkg::FWD_BUFFER && motor_running_in &&
		!continuous;

	ddo_pkg::direct_data_s buf_data;
	logic                  buf_full;

	// edge history of the launch input
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			launch_prev <= 1'b0;
		else if (clk_en_in)
			launch_prev <= launch_in;
	end

	// change reference, also taken on buffered launches
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			latched <= '0;
		else if (clk_en_in && launch_ev)
			latched <= data_s2;
	end

	// single slot; a newer buffered launch overwrites the held entry
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_data <= '0;
			buf_full <= 1'b0;
		end else if (clk_en_in) begin
			if (launch_ev && to_buffer) begin
				buf_data <= data_s2;
				buf_full <= 1'b1;
			end else if (launch_ev) begin
				buf_full <= 1'b0;
			end else if (op_complete_in) begin
				buf_full <= 1'b0;
			end
		end
	end

	// execution slot; a launch in the completion cycle beats the buffer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			exec_data_out  <= '0;
			exec_start_out <= 1'b0;
		end else if (clk_en_in) begin
			exec_start_out <= 1'b0;
			if (launch_ev && !to_buffer) begin
				exec_data_out  <= data_s2;
				exec_start_out <= 1'b1;
			end else if (!launch_ev && op_complete_in && buf_full) begin
				exec_data_out  <= buf_data;
				exec_start_out <= 1'b1;
			end
		end
	end

	// status flags back to the scanner, all registered
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.direct_command_ready <= 1'b0;
			link.queue_slot_full      <= 1'b0;
			link.write_done           <= 1'b0;
			field_sel_out             <= ddo_pkg::FIELD_SEL_RESET;
		end else if (clk_en_in) begin
			link.direct_command_ready <= !buf_full && !lvl_disabled;
			link.queue_slot_full <= buf_full;
			link.write_done      <= wr_state == ddo_pkg::WR_DONE;
			field_sel_out        <= field_sel;
		end
	end

	// ack stands until the synced launch input is low again
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			link.launch_acknowledge <= 1'b0;
		else if (clk_en_in) begin
			if (launch_ev)
				link.launch_acknowledge <= 1'b1;
			else if (!launch_in)
				link.launch_acknowledge <= 1'b0;
		end
	end
endmodule : direct_data_command_handler

// ### ddo_scanner.sv
// scanner end: software-facing registers driving the cyclic image
// assumes the driver end answers over ddo_if; link inputs synchronised
`timescale 1ns/1ns
module ddo_scanner (
	// clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	// software port
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output logic             irq_out,
	// link
	ddo_if.scanner           link
);
	logic [3:0] st_s1, st_s2;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_s1 <= 4'h0;
			st_s2 <= 4'h0;
		end else if (clk_en_in) begin
			st_s1 <= {link.direct_command_ready, link.queue_slot_full,
				link.write_done, link.launch_acknowledge};
			st_s2 <= st_s1;
		end
	end

	logic [ddo_pkg::NUM_EV-1:0] ev_now, ev_prev, events, mask;
	assign ev_now = {st_s2[2], st_s2[1], st_s2[0]};

	// software sets and drops the launch bit directly; ready and acknowledge are not checked here
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.fixed_in      <= 16'h0;
			link.data          <= '0;
			link.forward       <= ddo_pkg::FWD_EXEC;
			link.param_id      <= 16'h0;
			link.param_val     <= 32'h0;
			link.write_request <= 1'b0;
		end else if (clk_en_in && wr_in) begin
			unique case (addr_in)
				ddo_pkg::REG_CTRL: begin
					link.fixed_in[0] <= wdata_in[ddo_pkg::CTRL_LAUNCH];
					link.fixed_in[ddo_pkg::LAUNCH_COND_BIT] <=
						wdata_in[ddo_pkg::CTRL_LEVEL];
					link.write_request <= wdata_in[ddo_pkg::CTRL_WRREQ];
				end
				ddo_pkg::REG_OP_TYPE:  link.data.op_type    <= wdata_in[15:0];
				ddo_pkg::REG_POSITION: link.data.position   <= wdata_in;
				ddo_pkg::REG_SPEED:    link.data.speed      <= wdata_in;
				ddo_pkg::REG_RATE:     link.data.start_rate <= wdata_in;
				ddo_pkg::REG_DECEL:    link.data.stop_decel <= wdata_in;
				ddo_pkg::REG_CURRENT:  link.data.current    <= wdata_in[15:0];
				ddo_pkg::REG_FORWARD:  link.forward         <= wdata_in[15:0];
				ddo_pkg::REG_PARAM_ID: link.param_id        <= wdata_in[15:0];
				ddo_pkg::REG_PARAM_V:  link.param_val       <= wdata_in;
				default: ;
			endcase
		end
	end

	// sticky events on rising status edges; set wins over clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ev_prev <= '0;
			events  <= '0;
			mask    <= '0;
			irq_out <= 1'b0;
		end else if (clk_en_in) begin
			ev_prev <= ev_now;
			if (wr_in && addr_in == ddo_pkg::REG_EVENTS)
				events <= (events & ~wdata_in[ddo_pkg::NUM_EV-1:0]) |
					(ev_now & ~ev_prev);
			else
				events <= events | (ev_now & ~ev_prev);
			if (wr_in && addr_in == ddo_pkg::REG_MASK)
				mask <= wdata_in[ddo_pkg::NUM_EV-1:0];
			irq_out <= |(events & mask);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rdata_out <= 32'h0;
		else if (clk_en_in) begin
			rdata_out <= 32'h0;
			if (rd_in) begin
				unique case (addr_in)
					ddo_pkg::REG_CTRL: rdata_out <= {29'h0,
						link.fixed_in[ddo_pkg::LAUNCH_COND_BIT],
						link.write_request, link.fixed_in[0]};
					ddo_pkg::REG_POSITION: rdata_out <= link.data.position;
					ddo_pkg::REG_STATUS:   rdata_out <= {28'h0, st_s2};
					ddo_pkg::REG_EVENTS:   rdata_out <= {29'h0, events};
					ddo_pkg::REG_MASK:     rdata_out <= {29'h0, mask};
					default:               rdata_out <= 32'h0;
				endcase
			end
		end
	end
endmodule : ddo_scanner

// ### ddo_asserts.sv
// link checker for the direct data handler: scanner end meets driver end
// assumes one clock; sees only the link signals, instanced by the bench
`timescale 1ns/1ns
module ddo_asserts (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	// link
	input wire logic [15:0] fixed_in,
	input wire logic [15:0] forward,
	input wire logic        write_request,
	input wire logic        write_done,
	input wire logic        direct_command_ready,
	input wire logic        launch_acknowledge,
	input wire logic        queue_slot_full
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// windows allow two sync flops and a register at each end
	sequence s_ack_up;
		##[1:6] launch_acknowledge;
	endsequence
	sequence s_ack_down;
		##[1:6] !launch_acknowledge;
	endsequence
	sequence s_done_up;
		##[2:8] write_done;
	endsequence
	sequence s_done_down;
		##[1:6] !write_done;
	endsequence

	a_ack_after_launch: assert property (
		$rose(fixed_in[0]) && direct_command_ready |-> s_ack_up)
		else $error("launch not acknowledged");
	a_ack_holds_high: assert property (
		launch_acknowledge && fixed_in[0] |=> launch_acknowledge)
		else $error("acknowledge dropped while launch high");
	a_ack_drops_low: assert property (
		$fell(fixed_in[0]) |-> s_ack_down)
		else $error("acknowledge stuck after launch low");
	a_ack_needs_launch: assert property (
		$rose(launch_acknowledge) |-> fixed_in[0])
		else $error("acknowledge without launch");
	a_done_after_req: assert property (
		$rose(write_request) |-> s_done_up)
		else $error("write done missing");
	a_done_holds_high: assert property (
		write_done && write_request |=> write_done)
		else $error("write done dropped early");
	a_done_drops_low: assert property (
		$fell(write_request) |-> s_done_down)
		else $error("write done stuck high");
	a_done_needs_req: assert property (
		$rose(write_done) |-> write_request)
		else $error("write done without request");
	a_full_from_buffer: assert property (
		$rose(queue_slot_full) |-> forward == 16'h0001)
		else $error("full without buffer destination");
	a_full_blocks_ready: assert property (
		$rose(queue_slot_full) |-> ##[0:2] !direct_command_ready)
		else $error("ready while slot full");
endmodule : ddo_asserts

// ### testbench.sv
// bench: scanner end and driver end joined by one link
// assumes 100 MHz clock; the bench plays the motion generator
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	n_mismatch++; $display("mismatch at %0t: got %h exp %h", $time, a, e); \
	end end
module testbench;
	logic                  clk_in;
	logic                  clk_en_in;
	logic                  rst_n_in;
	logic                  wr_in;
	logic                  rd_in;
	logic                  motor_running_in;
	logic                  op_complete_in;
	logic                  exec_start_out;
	logic                  irq_out;
	logic [3:0]            addr_in;
	logic [31:0]           wdata_in;
	logic [31:0]           rdata_out;
	logic [31:0]           field_sel_out;
	logic [31:0]           rv;
	logic [31:0]           last_pos;
	ddo_pkg::direct_data_s exec_data_out;
	int                    n_mismatch;
	int                    samples_checked;
	int                    n_start;
	int                    cycles;

	ddo_if ddo_if_i ();
	ddo_scanner ddo_scanner_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.irq_out(irq_out), .link(ddo_if_i));
	direct_data_command_handler direct_data_command_handler_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
		.link(ddo_if_i), .motor_running_in(motor_running_in),
		.op_complete_in(op_complete_in), .exec_start_out(exec_start_out),
		.exec_data_out(exec_data_out), .field_sel_out(field_sel_out));
	ddo_asserts ddo_asserts_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.fixed_in(ddo_if_i.fixed_in), .forward(ddo_if_i.forward),
		.write_request(ddo_if_i.write_request),
		.write_done(ddo_if_i.write_done),
		.direct_command_ready(ddo_if_i.direct_command_ready),
		.launch_acknowledge(ddo_if_i.launch_acknowledge),
		.queue_slot_full(ddo_if_i.queue_slot_full));

	task stop_test;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(posedge clk_in);
		rv = rdata_out;
	endtask : rd
	task wait_for(input int w, input logic v);
		int k;
		for (k = 0; k < 30; k++) begin
			if ((w == 0 ? ddo_if_i.launch_acknowledge
				: ddo_if_i.write_done) === v) break;
			@(posedge clk_in);
		end
		`CHK(k < 30, 1'b1)
	endtask : wait_for
	task launch(input logic [31:0] base);
		wr(ddo_pkg::REG_CTRL, base | 32'h1);
		wait_for(0, 1'b1);
		wr(ddo_pkg::REG_CTRL, base);
		wait_for(0, 1'b0);
		wt(2);
	endtask : launch
	task load(input logic [31:0] op, input logic [31:0] pos,
		input logic [31:0] fwd);
		wr(ddo_pkg::REG_OP_TYPE, op);
		wr(ddo_pkg::REG_POSITION, pos);
		wr(ddo_pkg::REG_FORWARD, fwd);
	endtask : load
	task pw(input logic [31:0] val, input logic [31:0] base);
		wr(ddo_pkg::REG_PARAM_ID, 32'h0000_6114);
		wr(ddo_pkg::REG_PARAM_V, val);
		wr(ddo_pkg::REG_CTRL, base | 32'h2);
		wait_for(1, 1'b1);
		wr(ddo_pkg::REG_CTRL, base);
		wait_for(1, 1'b0);
	endtask : pw
	task complete;
		@(posedge clk_in);
		op_complete_in <= 1'b1;
		@(posedge clk_in);
		op_complete_in <= 1'b0;
		wt(8);
	endtask : complete

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch++;
			stop_test();
		end
		if (exec_start_out === 1'b1) begin
			n_start <= n_start + 1;
			last_pos <= exec_data_out.position;
		end
	end

	initial begin
		{wr_in, rd_in, motor_running_in, op_complete_in} = 4'h0;
		clk_en_in = 1'b1;
		addr_in = 4'h0;
		wdata_in = 32'h0;
		{n_mismatch, samples_checked, n_start, cycles} = 0;
		rst_n_in = 1'b0;
		wt(5);
		rst_n_in <= 1'b1;
		wt(4);
		`CHK(field_sel_out, 32'h0000_0001)
		`CHK(ddo_if_i.direct_command_ready, 1'b1)
		rd(4'hd);
		`CHK(rv, 32'h0)
		wr(ddo_pkg::REG_MASK, 32'h1);
		// edge start into the execution slot
		load(32'h1, 32'h0000_1388, 32'h0);
		launch(32'h0);
		`CHK(n_start, 1)
		`CHK(last_pos, 32'h0000_1388)
		`CHK(exec_data_out.op_type, 16'h0001)
		`CHK(irq_out, 1'b1)
		wr(ddo_pkg::REG_MASK, 32'h0);
		wt(2);
		`CHK(irq_out, 1'b0)
		wr(ddo_pkg::REG_EVENTS, 32'h7);
		rd(ddo_pkg::REG_EVENTS);
		`CHK(rv[0], 1'b0)
		// buffered while running, started on completion
		motor_running_in <= 1'b1;
		load(32'h1, 32'h64, 32'h1);
		launch(32'h0);
		`CHK(n_start, 1)
		`CHK(ddo_if_i.queue_slot_full, 1'b1)
		rd(ddo_pkg::REG_STATUS);
		`CHK(rv, 32'h4)
		rd(ddo_pkg::REG_EVENTS);
		`CHK(rv, 32'h5)
		complete();
		`CHK(n_start, 2)
		`CHK(last_pos, 32'h64)
		`CHK(ddo_if_i.queue_slot_full, 1'b0)
		// execution load discards the held entry
		load(32'h1, 32'h12c, 32'h1);
		launch(32'h0);
		load(32'h1, 32'h190, 32'h0);
		launch(32'h0);
		`CHK(last_pos, 32'h190)
		`CHK(ddo_if_i.queue_slot_full, 1'b0)
		complete();
		`CHK(n_start, 3)
		// stopped, then continuous: buffer selection ignored
		motor_running_in <= 1'b0;
		load(32'h1, 32'h1f4, 32'h1);
		launch(32'h0);
		`CHK(n_start, 4)
		motor_running_in <= 1'b1;
		load(32'h10, 32'h258, 32'h0);
		launch(32'h0);
		load(32'h1, 32'h2bc, 32'h1);
		launch(32'h0);
		`CHK(n_start, 6)
		`CHK(ddo_if_i.queue_slot_full, 1'b0)
		// level start with position as the trigger field
		motor_running_in <= 1'b0;
		pw(32'hffff_fffb, 32'h0);
		`CHK(field_sel_out, 32'hffff_fffb)
		load(32'h1, 32'h1b58, 32'h0);
		wr(ddo_pkg::REG_CTRL, 32'h5);
		wait_for(0, 1'b1);
		wt(4);
		`CHK(n_start, 7)
		wr(ddo_pkg::REG_SPEED, 32'h3e7);
		wt(10);
		`CHK(n_start, 7)
		wr(ddo_pkg::REG_POSITION, 32'h0bb8);
		wt(10);
		`CHK(n_start, 8)
		`CHK(last_pos, 32'h0bb8)
		wr(ddo_pkg::REG_POSITION, 32'h0bb8);
		wt(10);
		`CHK(n_start, 8)
		// all fields, then current only, then disabled
		pw(32'h1, 32'h5);
		wr(ddo_pkg::REG_SPEED, 32'h3e8);
		wt(10);
		`CHK(n_start, 9)
		pw(32'hffff_ffff, 32'h5);
		wr(ddo_pkg::REG_RATE, 32'h64);
		wt(10);
		`CHK(n_start, 9)
		wr(ddo_pkg::REG_CURRENT, 32'h3e8);
		wt(10);
		`CHK(n_start, 10)
		wr(ddo_pkg::REG_CTRL, 32'h4);
		wait_for(0, 1'b0);
		pw(32'h0, 32'h4);
		wt(4);
		`CHK(ddo_if_i.direct_command_ready, 1'b0)
		// a write while the enable is low must leave no trace
		clk_en_in <= 1'b0;
		wr(ddo_pkg::REG_MASK, 32'h7);
		clk_en_in <= 1'b1;
		rd(ddo_pkg::REG_MASK);
		`CHK(rv, 32'h0)
		stop_test();
	end
endmodule : testbench
